//--- hw/iaf_top.sv
`default_nettype none
// Functional notes
// (RULE1) host puts the block on even address
// (RULE2) fetch twelve words in fixed order
// (RULE3) 3-bit length code gives 2^n entries
// (RULE4) ring base: low word plus byte
// (RULE5) host aligns ring entries to 8 bytes
// (RULE6) written ring lengths override decoded lengths
// (RULE7) first wire bit one means logical
// (RULE8) physical address must equal station address
// (RULE9) crc top six bits pick hash bit
// (RULE10) zero hash rejects logical except broadcast
// (RULE11) broadcast bypasses hash, obeys disable and promiscuous
// (RULE12) host moves fcs to receiver in loopback
// (RULE13) station bit zero is first, zero
// (RULE14) six bytes map lsb first, low first
// (RULE15) mode word copied into mode register
// (RULE16) rx entry status is word1 upper byte
// (RULE17) rings step 8 bytes, wrap to base
module iaf_top
  import iaf_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,                          // destination byte buffer
  parameter int LEN_W      = 16                          // ring length register width
)
(
  input  wire logic              mclk,                   // core clock, 250 MHz
  input  wire logic              rst_b,                  // sync reset, low
  input  wire logic              init_start,             // pulse: fetch the block
  input  wire logic [ADDR_W-1:0] init_block_base,        // block address in host memory
  output logic                   mem_rd_req,             // pulse: read one word
  output logic [ADDR_W-1:0]      mem_rd_addr,            // word byte address
  input  wire logic              mem_rd_valid,           // pulse: read data present
  input  wire logic [15:0]       mem_rd_data,            // read word
  output logic                   init_busy,              // fetch in progress
  output logic                   init_done,              // block applied
  output logic [15:0]            mode_control_register,  // copied mode word
  output logic [47:0]            station_address,        // own physical address
  output logic [63:0]            multicast_hash_filter,  // logical filter
  output logic [ADDR_W-1:0]      rx_ring_base,           // rx ring start
  output logic [ADDR_W-1:0]      tx_ring_base,           // tx ring start
  output logic [2:0]             rx_ring_length_code,    // rx length code
  output logic [2:0]             tx_ring_length_code,    // tx length code
  output logic [LEN_W-1:0]       rx_ring_length,         // rx entries in use
  output logic [LEN_W-1:0]       tx_ring_length,         // tx entries in use
  input  wire logic              rx_len_wr,              // pulse: write rx length
  input  wire logic              tx_len_wr,              // pulse: write tx length
  input  wire logic [LEN_W-1:0]  len_wdata,              // length being written
  input  wire logic              rx_step,                // pulse: next rx entry
  input  wire logic              tx_step,                // pulse: next tx entry
  output logic [ADDR_W-1:0]      rx_entry_addr,          // current rx entry
  output logic [ADDR_W-1:0]      tx_entry_addr,          // current tx entry
  input  wire logic [15:0]       rx_entry_word1,         // word1 of current rx entry
  output logic [7:0]             rx_entry_status,        // status byte of that entry
  input  wire logic              da_valid,               // destination byte offered
  input  wire logic [7:0]        da_byte,                // byte, wire order
  output logic                   da_ready,               // fifo has room
  output logic                   addr_done,              // pulse: verdict ready
  output logic                   addr_accept,            // verdict: keep frame
  output logic                   addr_logical            // verdict: was logical
);
  // ring length must hold the largest decoded length
  if (LEN_W < 8)
  begin : g_bad_len
    $error("ring length width must be at least 8 bits");
  end

  typedef enum logic [1:0]
  {
    IAF_IDLE  = 2'b00,                                   // waiting for start
    IAF_ISSUE = 2'b01,                                   // request one word
    IAF_WAIT  = 2'b10                                    // wait for its data
  } iaf_state_t;

  iaf_state_t        state_r;                            // fetch state
  logic [3:0]        widx_r;                             // word being fetched
  logic [15:0]       words_r [INIT_WORDS];               // fetched block image
  logic              apply_r;                            // last word landed
  logic [LEN_W-1:0]  rx_idx_r;                           // current rx entry number
  logic [LEN_W-1:0]  tx_idx_r;                           // current tx entry number
  logic              f_valid;                            // fifo byte waiting
  logic [7:0]        f_byte;                             // fifo byte
  logic              f_pop;                              // filter takes the byte
  logic [2:0]        bcnt_r;                             // bytes of address taken
  logic [47:0]       da_r;                               // assembled address
  logic              decide_r;                           // verdict cycle
  logic [31:0]       crc;                                // running crc
  logic              is_bcast;                           // all ones
  logic              is_log;                             // logical address
  logic [5:0]        hash_idx;                           // hash bit select

  // destination bytes wait here; the filter stalls it until init is done
  iaf_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo
  (
    .clk       (mclk),
    .rst_b     (rst_b),
    .in_valid  (da_valid),
    .in_data   (da_byte),
    .in_ready  (da_ready),
    .out_valid (f_valid),
    .out_data  (f_byte),
    .out_ready (f_pop)
  );

  // hash crc over the six address bytes
  iaf_crc u_crc
  (
    .clk   (mclk),
    .rst_b (rst_b),
    .clr   (decide_r),
    .en    (f_pop),
    .din   (f_byte),
    .crc   (crc)
  );

  // fetch sequencer: one outstanding read, words in ascending order
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      state_r     <= IAF_IDLE;
      widx_r      <= '0;
      mem_rd_req  <= 1'b0;
      mem_rd_addr <= '0;
      init_busy   <= 1'b0;
      apply_r     <= 1'b0;
    end
    else
    begin
      mem_rd_req <= 1'b0;
      apply_r    <= 1'b0;
      unique case (state_r)
        IAF_IDLE:
        begin
          if (init_start)
          begin
            state_r   <= IAF_ISSUE;
            widx_r    <= '0;
            init_busy <= 1'b1;
          end
        end
        IAF_ISSUE:
        begin
          // low address bit forced clear: block is word aligned
          mem_rd_req  <= 1'b1;                           // RULE2
          mem_rd_addr <= {init_block_base[ADDR_W-1:1], 1'b0}
                         + {(ADDR_W-5)'(0), widx_r, 1'b0}; // RULE1
          state_r     <= IAF_WAIT;
        end
        IAF_WAIT:
        begin
          if (mem_rd_valid)
          begin
            if (widx_r == W_LAST)
            begin
              state_r   <= IAF_IDLE;
              init_busy <= 1'b0;
              apply_r   <= 1'b1;
            end
            else
            begin
              widx_r  <= widx_r + 4'h1;                  // RULE2
              state_r <= IAF_ISSUE;
            end
          end
        end
        default:
        begin
          state_r <= IAF_IDLE;                           // code 2'b11 is illegal
        end
      endcase
    end
  end

  // block image; data only, no reset needed
  always_ff @(posedge mclk)
  begin
    if ((state_r == IAF_WAIT) && mem_rd_valid)
      words_r[widx_r] <= mem_rd_data;
  end

  // apply the image in one edge so no half-loaded setup is ever visible
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      init_done             <= 1'b0;
      mode_control_register <= '0;
      station_address       <= '0;
      multicast_hash_filter <= '0;
      rx_ring_base          <= '0;
      tx_ring_base          <= '0;
      rx_ring_length_code   <= '0;
      tx_ring_length_code   <= '0;
    end
    else if (init_start)
      init_done <= 1'b0;                                 // config invalid while refetching
    else if (apply_r)
    begin
      init_done             <= 1'b1;
      mode_control_register <= words_r[W_MODE];          // RULE15
      // word n holds bytes 2n and 2n+1, low byte first on the wire
      station_address       <= {words_r[W_STA0+2], words_r[W_STA0+1],
                                words_r[W_STA0]};        // RULE14
      multicast_hash_filter <= {words_r[W_HASH0+3], words_r[W_HASH0+2],
                                words_r[W_HASH0+1], words_r[W_HASH0]};
      rx_ring_base          <= {words_r[W_RX_HI][BASE_HI_BITS-1:0],
                                words_r[W_RX_LO]};       // RULE4
      tx_ring_base          <= {words_r[W_TX_HI][BASE_HI_BITS-1:0],
                                words_r[W_TX_LO]};       // RULE4
      rx_ring_length_code   <= words_r[W_RX_HI][LEN_CODE_HI:LEN_CODE_LO]; // RULE3
      tx_ring_length_code   <= words_r[W_TX_HI][LEN_CODE_HI:LEN_CODE_LO]; // RULE3
    end
  end

  // ring lengths: decoded from the code, then overridable by software
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      rx_ring_length <= LEN_W'(1);
      tx_ring_length <= LEN_W'(1);
    end
    else if (apply_r)
    begin
      rx_ring_length <= LEN_W'(1) << words_r[W_RX_HI][LEN_CODE_HI:LEN_CODE_LO]; // RULE3
      tx_ring_length <= LEN_W'(1) << words_r[W_TX_HI][LEN_CODE_HI:LEN_CODE_LO]; // RULE3
    end
    else if (init_done)
    begin
      // zero would leave no entry to walk, so it is ignored
      if (rx_len_wr && (len_wdata != '0))
        rx_ring_length <= len_wdata;                     // RULE6
      if (tx_len_wr && (len_wdata != '0))
        tx_ring_length <= len_wdata;                     // RULE6
    end
  end

  // ring walkers; entries assumed 8-byte aligned by the host
  always_ff @(posedge mclk)
  begin
    if (!rst_b || apply_r)
    begin
      rx_idx_r <= '0;
      tx_idx_r <= '0;
    end
    else
    begin
      if (rx_step)
        rx_idx_r <= (rx_idx_r >= rx_ring_length - LEN_W'(1)) ? '0
                    : rx_idx_r + LEN_W'(1);              // RULE17
      if (tx_step)
        tx_idx_r <= (tx_idx_r >= tx_ring_length - LEN_W'(1)) ? '0
                    : tx_idx_r + LEN_W'(1);              // RULE17
    end
  end

  // entry addresses follow the indices one edge later
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      rx_entry_addr <= '0;
      tx_entry_addr <= '0;
    end
    else
    begin
      rx_entry_addr <= rx_ring_base + ADDR_W'({rx_idx_r, 3'h0}); // RULE5
      tx_entry_addr <= tx_ring_base + ADDR_W'({tx_idx_r, 3'h0}); // RULE17
    end
  end

  // status byte of the rx entry, sampled on each step
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      rx_entry_status <= '0;
    else if (rx_step)
      rx_entry_status <= rx_entry_word1[15:STATUS_LO];   // RULE16
  end

  // filter takes bytes only once configured and not while judging
  assign f_pop    = f_valid && init_done && !decide_r;
  assign is_bcast = &da_r;
  assign is_log   = da_r[0];                             // RULE7
  assign hash_idx = crc[HASH_MSB:HASH_LSB];              // RULE9

  // address assembly, first byte into bits 7:0
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      bcnt_r   <= '0;
      da_r     <= '0;
      decide_r <= 1'b0;
    end
    else
    begin
      decide_r <= 1'b0;
      if (f_pop)
      begin
        da_r[bcnt_r*8 +: 8] <= f_byte;                   // RULE14
        if (bcnt_r == 3'(DA_BYTES - 1))
        begin
          bcnt_r   <= '0;
          decide_r <= 1'b1;
        end
        else
          bcnt_r <= bcnt_r + 3'h1;
      end
    end
  end

  // verdict; promiscuous takes everything, broadcast never hashes
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      addr_done    <= 1'b0;
      addr_accept  <= 1'b0;
      addr_logical <= 1'b0;
    end
    else
    begin
      addr_done <= decide_r;
      if (decide_r)
      begin
        addr_logical <= is_log;                          // RULE7
        if (is_bcast)
          addr_accept <= !mode_control_register[MODE_BC_DIS]
                         || mode_control_register[MODE_PROM]; // RULE11
        else if (is_log)
          // an all-zero filter can never hit, so it rejects
          addr_accept <= mode_control_register[MODE_PROM]
                         || multicast_hash_filter[hash_idx]; // RULE10
        else
          // a station address with bit 0 set never reaches this compare
          addr_accept <= mode_control_register[MODE_PROM]
                         || (da_r == station_address);   // RULE8 RULE13
      end
    end
  end

  // fcs handover in loopback is left to host setup of mode and descriptors: RULE12

  sequence s_word_issue;
    (state_r == IAF_ISSUE) ##1 mem_rd_req;
  endsequence
  property p_word_addr;
    @(posedge mclk) disable iff (!rst_b)
    s_word_issue |-> (mem_rd_addr[0] == 1'b0) && ($past(widx_r) == widx_r);
  endproperty
  a_word_addr: assert property (p_word_addr) else $error("bad word address"); // RULE2

  property p_len_code;
    @(posedge mclk) disable iff (!rst_b)
    $rose(init_done) |-> (rx_ring_length == (LEN_W'(1) << rx_ring_length_code));
  endproperty
  a_len_code: assert property (p_len_code) else $error("rx length not 2^code"); // RULE3

  property p_base;
    @(posedge mclk) disable iff (!rst_b)
    $rose(init_done) |-> (tx_ring_base[15:0] == words_r[W_TX_LO]);
  endproperty
  a_base: assert property (p_base) else $error("tx base low word wrong"); // RULE4

  property p_mode;
    @(posedge mclk) disable iff (!rst_b)
    $rose(init_done) |-> (mode_control_register == words_r[W_MODE]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode not copied"); // RULE15

  property p_len_write;
    @(posedge mclk) disable iff (!rst_b)
    (init_done && !apply_r && rx_len_wr && (len_wdata != '0))
      |=> (rx_ring_length == $past(len_wdata));
  endproperty
  a_len_write: assert property (p_len_write) else $error("rx length write lost"); // RULE6

  property p_bcast;
    @(posedge mclk) disable iff (!rst_b)
    (decide_r && is_bcast && !mode_control_register[MODE_BC_DIS])
      |=> (addr_done && addr_accept);
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast rejected"); // RULE11

  property p_phys;
    @(posedge mclk) disable iff (!rst_b)
    (decide_r && !is_log && !mode_control_register[MODE_PROM]
     && (da_r != station_address)) |=> !addr_accept;
  endproperty
  a_phys: assert property (p_phys) else $error("foreign address accepted"); // RULE8

  property p_zero_hash;
    @(posedge mclk) disable iff (!rst_b)
    (decide_r && is_log && !is_bcast && (multicast_hash_filter == '0)
     && !mode_control_register[MODE_PROM]) |=> (addr_logical && !addr_accept);
  endproperty
  a_zero_hash: assert property (p_zero_hash) else $error("zero hash accepted"); // RULE10

  property p_wrap;
    @(posedge mclk) disable iff (!rst_b)
    (rx_step && !apply_r && (rx_idx_r == rx_ring_length - LEN_W'(1)))
      |=> ##1 (rx_entry_addr == rx_ring_base);
  endproperty
  a_wrap: assert property (p_wrap) else $error("rx ring did not wrap"); // RULE17

  property p_status;
    @(posedge mclk) disable iff (!rst_b)
    rx_step |=> (rx_entry_status == $past(rx_entry_word1[15:STATUS_LO]));
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong"); // RULE16
endmodule : iaf_top
`default_nettype wire

//--- hw/iaf_pkg.sv
`default_nettype none
// shared layout and crc constants for the init block fetch and address filter
package iaf_pkg;
  // init block word slots, counted in 16-bit words from the block base
  localparam int          INIT_WORDS     = 12;           // words fetched per init
  localparam logic [3:0]  W_MODE         = 4'h0;         // mode word
  localparam logic [3:0]  W_STA0         = 4'h1;         // station address 15:0
  localparam logic [3:0]  W_HASH0        = 4'h4;         // hash filter 15:0
  localparam logic [3:0]  W_RX_LO        = 4'h8;         // rx ring base 15:0
  localparam logic [3:0]  W_RX_HI        = 4'h9;         // rx code and base 23:16
  localparam logic [3:0]  W_TX_LO        = 4'ha;         // tx ring base 15:0
  localparam logic [3:0]  W_TX_HI        = 4'hb;         // tx code and base 23:16
  localparam logic [3:0]  W_LAST         = 4'hb;         // last word index
  // ring length code field in the upper pointer word
  localparam int          LEN_CODE_HI    = 15;           // code msb
  localparam int          LEN_CODE_LO    = 13;           // code lsb
  localparam int          BASE_HI_BITS   = 8;            // base bits 23:16 in low byte
  // mode word fields steering the filter
  localparam int          MODE_PROM      = 15;           // promiscuous enable
  localparam int          MODE_BC_DIS    = 14;           // broadcast disable
  // ring walking
  localparam int          ENTRY_SHIFT    = 3;            // 8 bytes per ring entry
  localparam int          ADDR_W         = 24;           // host address width
  localparam int          STATUS_LO      = 8;            // status byte in entry word1
  // destination address hashing
  localparam int          DA_BYTES       = 6;            // bytes in an address
  localparam logic [31:0] CRC_INIT       = 32'hffffffff; // crc preset
  localparam logic [31:0] CRC_POLY       = 32'hedb88320; // reflected ethernet poly
  localparam int          HASH_MSB       = 31;           // hash index msb in crc
  localparam int          HASH_LSB       = 26;           // hash index lsb in crc
endpackage : iaf_pkg
`default_nettype wire

//--- hw/iaf_fifo.sv
`default_nettype none
// small synchronous fifo; ready and valid both come from registers
module iaf_fifo
  import iaf_pkg::*;
#(
  parameter int W = 8,                                   // data width
  parameter int D = 8                                    // depth in words
)
(
  input  wire logic         clk,                         // core clock
  input  wire logic         rst_b,                       // sync reset, low
  input  wire logic         in_valid,                    // source offers a word
  input  wire logic [W-1:0] in_data,                     // source word
  output logic              in_ready,                    // room for a word
  output logic              out_valid,                   // a word is waiting
  output logic [W-1:0]      out_data,                    // oldest word
  input  wire logic         out_ready                    // sink takes the word
);
  localparam int AW = $clog2(D);

  // pointers wrap naturally, so only powers of two are served
  if ((D < 2) || ((1 << AW) != D))
  begin : g_bad_depth
    $error("fifo depth must be a power of two of at least 2");
  end

  logic [W-1:0]  mem_r [D];                              // storage
  logic [AW-1:0] wr_ptr_r;                               // next write slot
  logic [AW-1:0] rd_ptr_r;                               // next read slot
  logic [AW:0]   count_r;                                // words held
  logic [AW:0]   count_nxt;                              // words held next
  logic          push;                                   // write this cycle
  logic          pop;                                    // read this cycle

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_ptr_r];
  assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // storage write; no reset needed on data
  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data;
  end

  // pointers, level and registered flags
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      count_r   <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      wr_ptr_r  <= wr_ptr_r + AW'(push);
      rd_ptr_r  <= rd_ptr_r + AW'(pop);
      count_r   <= count_nxt;
      in_ready  <= (count_nxt != (AW+1)'(D));            // honest full
      out_valid <= (count_nxt != '0);                    // honest empty
    end
  end
endmodule : iaf_fifo
`default_nettype wire

//--- hw/iaf_crc.sv
`default_nettype none
// byte-wide ethernet crc, lsb first as the bits leave on the wire
module iaf_crc
  import iaf_pkg::*;
(
  input  wire logic        clk,                          // core clock
  input  wire logic        rst_b,                        // sync reset, low
  input  wire logic        clr,                          // preset for a new address
  input  wire logic        en,                           // fold in one byte
  input  wire logic [7:0]  din,                          // byte, bit 0 first
  output logic [31:0]      crc                           // running remainder
);
  // one byte through the reflected polynomial
  function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (r[0] ^ d[i])
        r = (r >> 1) ^ CRC_POLY;
      else
        r = r >> 1;
    end
    return r;
  endfunction

  // remainder register; clear wins, the filter never asks both at once
  always_ff @(posedge clk)
  begin
    if (!rst_b || clr)
      crc <= CRC_INIT;
    else if (en)
      crc <= step(crc, din);
  end
endmodule : iaf_crc
`default_nettype wire

//--- sim/iaf_host_mem.sv
`default_nettype none
// host memory image of the init block; answers each read after lat cycles
module iaf_host_mem
  import iaf_pkg::*;
(
  input  wire logic              mclk,         // core clock
  input  wire logic              mem_rd_req,   // read pulse
  input  wire logic [ADDR_W-1:0] mem_rd_addr,  // byte address
  input  wire logic [15:0]       mode_word,    // mode word to serve
  input  wire logic [15:0]       hash_word,    // every hash word
  input  wire logic [1:0]        lat,          // answer delay
  output logic                   mem_rd_valid, // data strobe
  output logic [15:0]            mem_rd_data   // read word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] img [12]; // block kept on an even base
  // fixed station and ring words, block base must have low five bits clear
  assign img = '{mode_word, 16'h2210, 16'h4433, 16'h6655, hash_word, hash_word,
                 hash_word, hash_word, 16'h5678, 16'h4012, 16'h9ab8, 16'he034};
  // data is scrambled once the strobe drops so stale values never match
  initial
  begin
    mem_rd_valid = 1'b0;
    mem_rd_data  = 16'h0;
    forever
    begin
      @(posedge mclk);
      if (mem_rd_req)
      begin
        repeat (lat) @(posedge mclk);
        #1 mem_rd_valid = 1'b1;
        mem_rd_data = img[mem_rd_addr[4:1]];
        @(posedge mclk);
        #1 mem_rd_valid = 1'b0;
        mem_rd_data = ~mem_rd_data;
      end
    end
  end
endmodule // iaf_host_mem
`default_nettype wire

//--- sim/iaf_top_tb.sv
`default_nettype none
module iaf_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import iaf_pkg::*;
  logic mclk, rst_b, init_start, mem_rd_req, mem_rd_valid, init_busy, init_done, rx_len_wr;
  logic tx_len_wr, rx_step, tx_step, da_valid, da_ready, addr_done, addr_accept, addr_logical;
  logic [23:0] init_block_base, mem_rd_addr, rx_ring_base, tx_ring_base, rx_entry_addr;
  logic [23:0] tx_entry_addr;
  logic [15:0] mem_rd_data, mode_control_register, rx_entry_word1, rx_ring_length, len_wdata;
  logic [15:0] tx_ring_length, mode_word, hash_word;
  logic [47:0] station_address, sta;
  logic [63:0] multicast_hash_filter;
  logic [2:0]  rx_ring_length_code, tx_ring_length_code;
  logic [7:0]  rx_entry_status, da_byte;
  logic [1:0]  lat;
  int mismatches, total_checks, cyc;
  iaf_top u_dut (.mclk, .rst_b, .init_start, .init_block_base, .mem_rd_req, .mem_rd_addr,
    .mem_rd_valid, .mem_rd_data, .init_busy, .init_done, .mode_control_register,
    .station_address, .multicast_hash_filter, .rx_ring_base, .tx_ring_base,
    .rx_ring_length_code, .tx_ring_length_code, .rx_ring_length, .tx_ring_length, .rx_len_wr,
    .tx_len_wr, .len_wdata, .rx_step, .tx_step, .rx_entry_addr, .tx_entry_addr,
    .rx_entry_word1, .rx_entry_status, .da_valid, .da_byte, .da_ready, .addr_done,
    .addr_accept, .addr_logical);
  iaf_host_mem u_mem (.mclk, .mem_rd_req, .mem_rd_addr, .mode_word, .hash_word, .lat,
    .mem_rd_valid, .mem_rd_data);
  // free running clock, 4 ns
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input bit ok, input string m);
    total_checks++;
    if (!ok)
    begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // filter word lighting the slot an address hashes to, same in all four words
  function automatic logic [15:0] hword(input logic [47:0] a);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 48; i++)
      c = (c >> 1) ^ ((c[0] ^ a[i]) ? CRC_POLY : 32'h0);
    return 16'h1 << c[HASH_LSB+3:HASH_LSB];
  endfunction
  // hang guard, well above the whole sequence
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      end_of_test();
    end
  end
  // fetch the block and wait for it to be applied
  task automatic do_init(input logic [15:0] m, input logic [15:0] h);
    mode_word = m;
    hash_word = h;
    @(posedge mclk) #1 init_start = 1'b1;
    @(posedge mclk) #1 init_start = 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk(init_busy === 1'b1, "not busy");
    for (int k = 0; k < 300 && init_done !== 1'b1; k++) @(posedge mclk);
    #1 chk(init_done === 1'b1 && init_busy === 1'b0, "init never done");
  endtask
  // six destination bytes, first byte holds the first wire bit
  task automatic send_da(input logic [47:0] a, input bit acc, input bit lg);
    for (int i = 0; i < DA_BYTES; i++)
    begin
      da_valid = 1'b1;
      da_byte  = a[8*i+:8];
      @(posedge mclk);
      while (da_ready !== 1'b1) @(posedge mclk);
      #1;
    end
    da_valid = 1'b0;
    // look a step after each edge, so the one-cycle done pulse is seen while it stands
    for (int k = 0; k < 20 && addr_done !== 1'b1; k++) @(posedge mclk) #1;
    chk(addr_done === 1'b1 && addr_accept === acc && addr_logical === lg, "verdict");
  endtask
  // advance the rx ring once, check the new entry and its status byte
  task automatic step_rx(input logic [23:0] ea, input logic [7:0] st);
    rx_entry_word1 = {st, 8'h5a};
    rx_step = 1'b1;
    @(posedge mclk) #1 rx_step = 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk(rx_entry_addr === ea && rx_entry_status === st, "ring step");
  endtask
  initial
  begin
    {rst_b, init_start, rx_len_wr, tx_len_wr, rx_step, tx_step, da_valid} = '0;
    {da_byte, len_wdata, rx_entry_word1, mode_word, hash_word} = '0;
    init_block_base = 24'h123440;
    lat = 2'd3;
    sta = 48'h665544332210;
    repeat (20) @(posedge mclk);
    #1 rst_b = 1'b1;
    // no mode below enables external loopback, so no fcs handover is due
    do_init(16'h8003, 16'h0000);
    chk(mode_control_register === 16'h8003 && station_address === sta, "mode sta");
    chk(rx_ring_base === 24'h125678 && tx_ring_base === 24'h349ab8, "ring base");
    chk(rx_ring_length_code === 3'h2 && rx_ring_length === 16'h4, "rx len");
    chk(tx_ring_length_code === 3'h7 && tx_ring_length === 16'h80, "tx len");
    lat = 2'd1;
    do_init(16'h0000, 16'h0000);
    send_da(sta, 1'b1, 1'b0);
    send_da(sta ^ 48'h000100000000, 1'b0, 1'b0);
    send_da('1, 1'b1, 1'b1);
    send_da(48'h0000005e0001, 1'b0, 1'b1);
    do_init(16'h4000, hword(48'h0000005e0001));
    send_da('1, 1'b0, 1'b1);
    send_da(48'h0000005e0001, 1'b1, 1'b1);
    send_da(48'h0000005e0003, hword(48'h0000005e0003) == hword(48'h0000005e0001), 1'b1);
    do_init(16'hc000, 16'h0000);
    send_da('1, 1'b1, 1'b1);
    send_da(48'h0a0b0c0d0e00, 1'b1, 1'b0);
    len_wdata = 16'h3;
    {rx_len_wr, tx_len_wr} = 2'b11;
    @(posedge mclk) #1 {rx_len_wr, tx_len_wr} = 2'b00;
    @(posedge mclk) #1 chk(rx_ring_length === 16'h3 && tx_ring_length === 16'h3, "len write");
    chk(tx_entry_addr === 24'h349ab8, "tx entry");
    step_rx(24'h125680, 8'h81);
    step_rx(24'h125688, 8'h42);
    step_rx(24'h125678, 8'hc3);
    end_of_test();
  end
endmodule // iaf_top_tb
`default_nettype wire
